// ===== core/rxfq_steer.sv
// How it works
// - flush selected and pin high discards frame
// - flushed frame restores write pointer from saved
// - nonzero threshold: flush only before crossing
// - inhibit: finish frame, then no new transmit
// - timers and state machines keep running
// - select 01 flush, 10 inhibit, else normal
// - function select bits reset to zero
// - single-frame status and mode bits read zero
// - command 40h reserved, no action
// - dual queues only with enable bit 11
// - both selections 0000 means single queue
// - queue two 0000 takes all but queue one's type
// - queue one 0000: only queue two fills
// - four-bit codes decode to frame types
// - non-STATION_MANAGEMENT_FRAME excludes MAC/void unless promiscuous
// - only copy-accepted frames are steered
// - equal selections force single queue
// - queue one selection wins on overlap
// - per-queue lock, commands 20h and 21h clear
// - per-queue data-present output
// - no read ack while data-present inactive
// - status bits 15-11; request 001 reads queue two
// - full buffer locks queue; 3Fh clears all
`timescale 1ns/1ns
module rxfq_steer import rxfq_pkg::*; #(
   parameter int PTR_W = 8
) (
   input logic clk_in,
   input logic rst_n_in,
   input logic flush_or_inhibit_input_in,
   input logic [7:0] np_addr_in,
   input logic [15:0] np_wdata_in,
   input logic np_wr_in,
   input logic np_rd_in,
   output logic [15:0] np_rdata_out,
   output logic np_rvalid_out,
   input logic rx_start_in,
   input rxfq_fclass_t rx_fclass_in,
   input logic rx_copy_in,
   input logic rx_byte_valid_in,
   input logic [7:0] rx_byte_in,
   input logic rx_end_in,
   input logic rx_good_in,
   output logic [2:0] address_detect_setting_out,
   output logic tx_inhibit_out,
   input logic host_req_in,
   input logic [2:0] host_service_request_code_in,
   output logic host_ack_out,
   output logic [PTR_W:0] host_addr_out,
   output logic queue_one_data_present_out,
   output logic queue_two_data_present_out,
   input logic mem_ready_in,
   output logic mem_wr_out,
   output logic [PTR_W:0] mem_addr_out,
   output logic [7:0] mem_data_out
);
   localparam int MW = PTR_W + 9;

   typedef struct packed {
      logic [2:0] sync;
      logic pin_lv;
      logic [15:0] mode1;
      logic [15:0] mode3;
      logic [15:0] frsel;
      logic [1:0] pincfg;
      logic [7:0] rxthr;
      rxfq_fsm_t state;
      logic cur_q;
      logic [7:0] bcnt;
      logic [1:0][PTR_W-1:0] rx_write_pointer;
      logic [1:0][PTR_W-1:0] rx_saved_start_pointer;
      logic [1:0][PTR_W-1:0] cpr;
      logic [1:0][PTR_W-1:0] rpr;
      logic [1:0] lock;
      logic [1:0] comp;
      logic [1:0] abt;
      logic [1:0] ovr;
      logic [1:0] dp;
      logic [15:0] rdata;
      logic rvalid;
      logic ack;
      logic txinh;
      logic [PTR_W:0] haddr;
   } rxfq_regs_t;

   rxfq_regs_t s;
   rxfq_regs_t n;
   logic push_v;
   logic [MW-1:0] push_d;
   logic [1:0] set_comp, set_abt, set_ovr, set_lock, clr_st, clr_lock;

   rxfq_stream_if #(.W(MW)) push_if ();
   rxfq_stream_if #(.W(MW)) mem_if ();

   rxfq_buf #(.W(MW)) u_buf (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .in_if(push_if.snk),
      .out_if(mem_if.src)
   );

   assign push_if.valid = push_v;
   assign push_if.data = push_d;
   assign mem_if.ready = mem_ready_in;

   function automatic logic type_match(input logic [3:0] code, input rxfq_fclass_t fc,
                                       input logic promisc);
      logic logical_link_frame;
      logic hit;
      logical_link_frame = (fc == FC_SYNC_LLC) || (fc == FC_ASYNC_LLC);
      case (code)
         SEL_LLC: hit = logical_link_frame;
         SEL_SMT: hit = (fc == FC_SMT);
         SEL_NON_SMT: hit = (fc != FC_SMT) && (promisc || ((fc != FC_MAC) && (fc != FC_VOID)));
         SEL_IMPL: hit = (fc == FC_IMPL);
         SEL_MAC: hit = (fc == FC_MAC);
         SEL_SYNC_LLC: hit = (fc == FC_SYNC_LLC);
         SEL_ASYNC_LLC: hit = (fc == FC_ASYNC_LLC);
         SEL_VOID: hit = (fc == FC_VOID);
         SEL_ASYNC_SMT: hit = (fc == FC_ASYNC_LLC) || (fc == FC_SMT);
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   logic [3:0] sel1, sel2;
   logic promisc, dual_act, m1, m2, go_q1, go_q2, tgt_v, tgt_q;
   logic flush_cond, inh_cond, hq, hq_ok, take, full_cur;
   logic [PTR_W-1:0] wpr_cur, rx_saved_start_pointer_cur;

   assign sel1 = s.frsel[FRSEL_Q1_LSB +: 4];
   assign sel2 = s.frsel[FRSEL_Q2_LSB +: 4];
   assign promisc = (s.mode1[MODE1_ADDET_LSB +: 3] == ADDET_PROMISC);
   // equal codes include both 0000, which also lands here
   assign dual_act = s.mode3[MODE3_DUAL_BIT] && (sel1 != sel2);
   assign m1 = type_match(sel1, rx_fclass_in, promisc);
   assign m2 = type_match(sel2, rx_fclass_in, promisc);
   // in dual mode a 0000 first selection never matches, so queue one stays empty
   assign go_q1 = !dual_act || ((sel1 != SEL_OTHERS) && m1);
   assign go_q2 = dual_act && !go_q1 && ((sel2 == SEL_OTHERS) || m2);
   assign tgt_v = rx_copy_in && (go_q1 || go_q2);
   assign tgt_q = go_q2;

   assign wpr_cur = s.rx_write_pointer[s.cur_q];
   assign rx_saved_start_pointer_cur = s.rx_saved_start_pointer[s.cur_q];
   assign full_cur = (PTR_W'(wpr_cur + 1'b1) == s.rpr[s.cur_q]);
   // threshold compare uses bytes already taken, so a late pin is ignored
   assign flush_cond = (s.pincfg == PIN_FN_FLUSH) && s.pin_lv &&
                       ((s.rxthr == 8'h00) || (s.bcnt < s.rxthr));
   assign inh_cond = (s.pincfg == PIN_FN_INHIBIT) && s.pin_lv;

   assign hq_ok = (host_service_request_code_in == HOST_SERVICE_REQUEST_CODE_Q1) ||
                  (host_service_request_code_in == HOST_SERVICE_REQUEST_CODE_Q2);
   assign hq = (host_service_request_code_in == HOST_SERVICE_REQUEST_CODE_Q2);
   assign take = host_req_in && !s.ack && hq_ok && s.dp[hq] &&
                 (s.cpr[hq] != s.rpr[hq]);

   always_comb begin
      n = s;
      push_v = 1'b0;
      push_d = '0;
      set_comp = 2'b00;
      set_abt = 2'b00;
      set_ovr = 2'b00;
      set_lock = 2'b00;
      clr_st = 2'b00;
      clr_lock = 2'b00;

      n.sync = {s.sync[1:0], flush_or_inhibit_input_in};
      if (s.sync[1] == s.sync[2]) begin
         n.pin_lv = s.sync[2];
      end
      // level only gates new starts in the transmitter; its timers never see it
      n.txinh = inh_cond;
      n.dp[0] = (s.cpr[0] != s.rpr[0]);
      n.dp[1] = (s.cpr[1] != s.rpr[1]);

      if (np_wr_in) begin
         case (np_addr_in)
            OFS_MODE1: n.mode1 = np_wdata_in & MODE1_RW_MASK;
            OFS_MODE3: n.mode3 = np_wdata_in;
            OFS_FRSEL: n.frsel = np_wdata_in & FRSEL_RW_MASK;
            OFS_PINCFG: n.pincfg = np_wdata_in[1:0];
            OFS_RXTHR: n.rxthr = np_wdata_in[7:0];
            OFS_CMD1: begin
               case (np_wdata_in[7:0])
                  CMD_CLR_LOCK1: clr_lock = 2'b01;
                  CMD_CLR_LOCK2: clr_lock = 2'b10;
                  CMD_CLR_ALL: clr_lock = 2'b11;
                  default: clr_lock = 2'b00;
               endcase
            end
            // 40h and every other code here is accepted and does nothing
            OFS_CMD2: clr_lock = 2'b00;
            default: clr_lock = 2'b00;
         endcase
      end

      n.rvalid = np_rd_in;
      n.rdata = 16'h0000;
      if (np_rd_in) begin
         case (np_addr_in)
            OFS_MODE1: n.rdata = s.mode1;
            OFS_MODE3: n.rdata = s.mode3;
            OFS_FRSEL: n.rdata = s.frsel;
            OFS_PINCFG: n.rdata = {14'h0000, s.pincfg};
            OFS_RXTHR: n.rdata = {8'h00, s.rxthr};
            OFS_STATUS_TWO_UPPER: begin
               // bits 10 and 9 stay zero, single-frame mode is gone
               n.rdata = {s.comp[0], s.cpr[0] == s.rpr[0], s.abt[0], s.lock[0], s.ovr[0],
                          11'h000};
               clr_st[0] = 1'b1;
            end
            OFS_STATUS_THREE_UPPER: begin
               n.rdata = {s.comp[1], s.cpr[1] == s.rpr[1], s.abt[1], s.lock[1], s.ovr[1],
                          11'h000};
               clr_st[1] = 1'b1;
            end
            default: n.rdata = 16'h0000;
         endcase
      end

      unique case (s.state)
         ST_IDLE: begin
            if (rx_start_in && tgt_v) begin
               if (s.lock[tgt_q]) begin
                  set_ovr[tgt_q] = 1'b1;
               end else begin
                  n.state = ST_RECV;
                  n.cur_q = tgt_q;
                  n.rx_saved_start_pointer[tgt_q] = s.rx_write_pointer[tgt_q];
                  n.bcnt = 8'h00;
               end
            end
         end
         ST_RECV: begin
            if (flush_cond) begin
               n.rx_write_pointer[s.cur_q] = rx_saved_start_pointer_cur;
               set_abt[s.cur_q] = 1'b1;
               n.state = rx_end_in ? ST_IDLE : ST_DROP;
            end else if (rx_byte_valid_in) begin
               if (full_cur) begin
                  set_lock[s.cur_q] = 1'b1;
                  set_ovr[s.cur_q] = 1'b1;
                  n.rx_write_pointer[s.cur_q] = rx_saved_start_pointer_cur;
                  n.state = ST_DROP;
               end else if (!push_if.ready) begin
                  // memory stalled past both slots; the ring cannot wait
                  set_ovr[s.cur_q] = 1'b1;
                  n.rx_write_pointer[s.cur_q] = rx_saved_start_pointer_cur;
                  n.state = ST_DROP;
               end else begin
                  push_v = 1'b1;
                  push_d = {s.cur_q, wpr_cur, rx_byte_in};
                  n.rx_write_pointer[s.cur_q] = wpr_cur + 1'b1;
                  n.bcnt = (s.bcnt == 8'hff) ? s.bcnt : s.bcnt + 8'h01;
               end
            end else if (rx_end_in) begin
               if (rx_good_in) begin
                  n.cpr[s.cur_q] = wpr_cur;
                  set_comp[s.cur_q] = 1'b1;
               end else begin
                  n.rx_write_pointer[s.cur_q] = rx_saved_start_pointer_cur;
                  set_abt[s.cur_q] = 1'b1;
               end
               n.state = ST_IDLE;
            end
         end
         ST_DROP: begin
            if (rx_end_in) begin
               n.state = ST_IDLE;
            end
         end
      endcase

      n.ack = take;
      if (take) begin
         n.haddr = {hq, s.rpr[hq]};
         n.rpr[hq] = s.rpr[hq] + 1'b1;
      end

      // a hardware set in the clearing cycle survives
      n.comp = (s.comp & ~clr_st) | set_comp;
      n.abt = (s.abt & ~clr_st) | set_abt;
      n.ovr = (s.ovr & ~clr_st) | set_ovr;
      n.lock = (s.lock & ~clr_lock) | set_lock;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s <= '0;
         s.mode1 <= MODE1_RST;
         s.mode3 <= MODE3_RST;
         s.frsel <= FRSEL_RST;
         s.pincfg <= PINCFG_RST;
         s.rxthr <= RXTHR_RST;
         s.state <= ST_IDLE;
      end else begin
         s <= n;
      end
   end

   assign np_rdata_out = s.rdata;
   assign np_rvalid_out = s.rvalid;
   assign address_detect_setting_out = s.mode1[MODE1_ADDET_LSB +: 3];
   assign tx_inhibit_out = s.txinh;
   assign host_ack_out = s.ack;
   assign host_addr_out = s.haddr;
   assign queue_one_data_present_out = s.dp[0];
   assign queue_two_data_present_out = s.dp[1];
   assign mem_wr_out = mem_if.valid;
   assign mem_addr_out = mem_if.data[MW-1:8];
   assign mem_data_out = mem_if.data[7:0];

   logic flush_evt, full_evt, dp_hq, rd_status_two_upper, rd_mode1;
   assign flush_evt = (s.state == ST_RECV) && flush_cond;
   assign full_evt = (s.state == ST_RECV) && !flush_cond && rx_byte_valid_in && full_cur;
   assign dp_hq = s.dp[hq];
   assign rd_status_two_upper = np_rd_in && (np_addr_in == OFS_STATUS_TWO_UPPER);
   assign rd_mode1 = np_rd_in && (np_addr_in == OFS_MODE1);

   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_flush_restore: assert property (flush_evt |=> wpr_cur == $past(rx_saved_start_pointer_cur))
      else $error("flush did not restore write pointer");
   a_late_no_flush: assert property ((s.state == ST_RECV) && (s.rxthr != 8'h00) &&
      (s.bcnt >= s.rxthr) && !rx_byte_valid_in && !rx_end_in |=> s.state == ST_RECV)
      else $error("frame flushed after threshold crossed");
   a_inhibit_map: assert property (s.txinh == $past(inh_cond))
      else $error("inhibit output does not follow pin and select");
   a_ack_needs_data: assert property (s.ack |-> $past(dp_hq))
      else $error("read acknowledged without data present");
   a_single_queue: assert property ((s.state == ST_IDLE) && rx_start_in &&
      rx_copy_in && !dual_act && !s.lock[0] |=> (s.state == ST_RECV) && !s.cur_q)
      else $error("single queue frame not taken into queue one");
   a_locked_refuse: assert property ((s.state == ST_IDLE) && rx_start_in && tgt_v &&
      s.lock[tgt_q] |=> s.state == ST_IDLE)
      else $error("locked queue accepted a frame");
   a_full_locks: assert property (full_evt |=>
      s.lock[s.cur_q] && (s.state == ST_DROP))
      else $error("full queue did not lock");
   a_clear_all: assert property (np_wr_in && (np_addr_in == OFS_CMD1) &&
      (np_wdata_in[7:0] == CMD_CLR_ALL) && !full_evt |=> s.lock == 2'b00)
      else $error("clear all did not clear locks");
   a_status_two_upper_rsvd: assert property (s.rvalid && $past(rd_status_two_upper) |->
      s.rdata[ST_SFR_BIT:ST_FCOV_BIT] == 2'b00)
      else $error("reserved status bits read nonzero");
   a_mode1_rsvd: assert property (s.rvalid && $past(rd_mode1) |->
      !s.rdata[MODE1_SFR_BIT])
      else $error("reserved mode bit read nonzero");

   c_flush: cover property (flush_evt ##1 s.state == ST_DROP);
   c_q2_frame: cover property ((s.state == ST_RECV) && s.cur_q && rx_end_in && rx_good_in);
   c_host_ack: cover property (s.ack && s.haddr[PTR_W]);
   c_inhibit: cover property (s.txinh);
endmodule // rxfq_steer

// ===== core/rxfq_pkg.sv
package rxfq_pkg;
   // node processor register offsets (8-bit address)
   localparam logic [7:0] OFS_MODE1 = 8'h00;
   localparam logic [7:0] OFS_CMD1 = 8'h02;
   localparam logic [7:0] OFS_CMD2 = 8'h03;
   localparam logic [7:0] OFS_STATUS_TWO_UPPER = 8'h08;
   localparam logic [7:0] OFS_STATUS_THREE_UPPER = 8'h0a;
   localparam logic [7:0] OFS_MODE3 = 8'h60;
   localparam logic [7:0] OFS_FRSEL = 8'h61;
   localparam logic [7:0] OFS_PINCFG = 8'h62;
   localparam logic [7:0] OFS_RXTHR = 8'h63;

   // reset values
   localparam logic [15:0] MODE1_RST = 16'h0000;
   localparam logic [15:0] MODE3_RST = 16'h0000;
   localparam logic [15:0] FRSEL_RST = 16'h0000;
   localparam logic [1:0] PINCFG_RST = 2'h0;
   localparam logic [7:0] RXTHR_RST = 8'h00;

   // field layout
   localparam logic [15:0] MODE1_RW_MASK = 16'h7fff;
   localparam logic [15:0] FRSEL_RW_MASK = 16'hc0ff;
   localparam int MODE1_SFR_BIT = 15;
   localparam int MODE1_ADDET_LSB = 0;
   localparam int MODE3_DUAL_BIT = 11;
   localparam int FRSEL_Q1_LSB = 0;
   localparam int FRSEL_Q2_LSB = 4;
   localparam int ST_COMP_BIT = 15;
   localparam int ST_BMT_BIT = 14;
   localparam int ST_ABT_BIT = 13;
   localparam int ST_BFL_BIT = 12;
   localparam int ST_OVR_BIT = 11;
   localparam int ST_SFR_BIT = 10;
   localparam int ST_FCOV_BIT = 9;
   localparam logic [2:0] ADDET_PROMISC = 3'h7;

   // commands
   localparam logic [7:0] CMD_CLR_LOCK1 = 8'h20;
   localparam logic [7:0] CMD_CLR_LOCK2 = 8'h21;
   localparam logic [7:0] CMD_CLR_ALL = 8'h3f;
   localparam logic [7:0] CMD_SFR_RSVD = 8'h40;

   // queue type codes
   localparam logic [3:0] SEL_OTHERS = 4'h0;
   localparam logic [3:0] SEL_LLC = 4'h1;
   localparam logic [3:0] SEL_SMT = 4'h2;
   localparam logic [3:0] SEL_NON_SMT = 4'h3;
   localparam logic [3:0] SEL_IMPL = 4'h4;
   localparam logic [3:0] SEL_MAC = 4'h5;
   localparam logic [3:0] SEL_SYNC_LLC = 4'h6;
   localparam logic [3:0] SEL_ASYNC_LLC = 4'h7;
   localparam logic [3:0] SEL_VOID = 4'h8;
   localparam logic [3:0] SEL_ASYNC_SMT = 4'h9;

   // host service request codes
   localparam logic [2:0] HOST_SERVICE_REQUEST_CODE_Q1 = 3'h0;
   localparam logic [2:0] HOST_SERVICE_REQUEST_CODE_Q2 = 3'h1;

   // pin function select
   localparam logic [1:0] PIN_FN_NORMAL = 2'h0;
   localparam logic [1:0] PIN_FN_FLUSH = 2'h1;
   localparam logic [1:0] PIN_FN_INHIBIT = 2'h2;

   typedef enum logic [2:0] {
      FC_SYNC_LLC = 3'h0,
      FC_ASYNC_LLC = 3'h1,
      FC_SMT = 3'h2,
      FC_IMPL = 3'h3,
      FC_MAC = 3'h4,
      FC_VOID = 3'h5,
      FC_OTHER = 3'h6
   } rxfq_fclass_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RECV = 3'b010,
      ST_DROP = 3'b100
   } rxfq_fsm_t;
endpackage

// ===== core/rxfq_stream_if.sv
`timescale 1ns/1ns
interface rxfq_stream_if #(parameter int W = 8) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ===== core/rxfq_buf.sv
`timescale 1ns/1ns
module rxfq_buf #(parameter int W = 8) (
   input logic clk_in,
   input logic rst_n_in,
   rxfq_stream_if.snk in_if,
   rxfq_stream_if.src out_if
);
   typedef struct packed {
      logic v0;
      logic v1;
      logic [W-1:0] d0;
      logic [W-1:0] d1;
   } rxfq_buf_t;

   rxfq_buf_t s;
   rxfq_buf_t n;
   logic pop;
   logic push;

   // ready only from the spare slot, so a full buffer really refuses
   assign in_if.ready = !s.v1;
   assign out_if.valid = s.v0;
   assign out_if.data = s.d0;
   assign pop = s.v0 && out_if.ready;
   assign push = in_if.valid && !s.v1;

   always_comb begin
      n = s;
      if (pop) begin
         n.v0 = s.v1;
         n.d0 = s.d1;
         n.v1 = 1'b0;
      end
      if (push) begin
         if (!n.v0) begin
            n.v0 = 1'b1;
            n.d0 = in_if.data;
         end else begin
            n.v1 = 1'b1;
            n.d1 = in_if.data;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   a_buf_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      s.v0 && !out_if.ready |=> s.v0 && $stable(s.d0))
      else $error("buffer head changed while stalled");
   c_buf_full: cover property (@(posedge clk_in) disable iff (!rst_n_in) s.v1 && in_if.valid);
endmodule // rxfq_buf

// ===== tb/rxfq_mem_model.sv
`timescale 1ns/1ns
module rxfq_mem_model (
   input wire logic clk_in,
   input wire logic slow_in,
   input wire logic mem_wr_in,
   input wire logic [8:0] mem_addr_in,
   input wire logic [7:0] mem_data_in,
   output logic mem_ready_out,
   output int q1_cnt_out,
   output int q2_cnt_out,
   output logic [7:0] last_data_out
);
   // two-state phase so the stall pattern starts from a known value
   bit ph;
   // slow mode stalls every other cycle so the buffer must hold words
   always @(negedge clk_in) begin
      ph <= ~ph;
      mem_ready_out <= ~slow_in | ph;
   end
   // address msb picks the queue
   always @(posedge clk_in) begin
      if (mem_wr_in && mem_ready_out) begin
         last_data_out <= mem_data_in;
         if (mem_addr_in[8])
            q2_cnt_out <= q2_cnt_out + 1;
         else
            q1_cnt_out <= q1_cnt_out + 1;
      end
   end
endmodule // rxfq_mem_model

// ===== tb/test_rx_flush_dual_queue_steering.sv
`timescale 1ns/1ns
module test_rx_flush_dual_queue_steering;
   import rxfq_pkg::*;
   logic clk, rst_n, pin, wr, rd, st, cp, bv, en, gd, hreq, slow;
   logic [7:0] addr, bt;
   logic [15:0] wd, rdata, rv;
   logic [2:0] hcode, addet;
   rxfq_fclass_t fc;
   logic rvalid, inh, ack, dp1, dp2, mrdy, mwr;
   logic [8:0] haddr, maddr;
   logic [7:0] mdata, mlast;
   int q1, q2, failures, n_compared;
   rxfq_steer uut (.clk_in(clk), .rst_n_in(rst_n), .flush_or_inhibit_input_in(pin),
      .np_addr_in(addr), .np_wdata_in(wd), .np_wr_in(wr), .np_rd_in(rd),
      .np_rdata_out(rdata), .np_rvalid_out(rvalid), .rx_start_in(st), .rx_fclass_in(fc),
      .rx_copy_in(cp), .rx_byte_valid_in(bv), .rx_byte_in(bt), .rx_end_in(en),
      .rx_good_in(gd), .address_detect_setting_out(addet), .tx_inhibit_out(inh),
      .host_req_in(hreq), .host_service_request_code_in(hcode), .host_ack_out(ack),
      .host_addr_out(haddr), .queue_one_data_present_out(dp1),
      .queue_two_data_present_out(dp2), .mem_ready_in(mrdy), .mem_wr_out(mwr),
      .mem_addr_out(maddr), .mem_data_out(mdata));
   rxfq_mem_model mem (.clk_in(clk), .slow_in(slow), .mem_wr_in(mwr), .mem_addr_in(maddr),
      .mem_data_in(mdata), .mem_ready_out(mrdy), .q1_cnt_out(q1), .q2_cnt_out(q2),
      .last_data_out(mlast));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      addr = a;
      wd = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
      int i;
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      d = 16'hdead;
      for (i = 0; i < 3; i++) begin
         if (rvalid === 1'b1) begin
            d = rdata;
            break;
         end
         @(negedge clk);
      end
   endtask
   // request held through the edge that sees the ack, then dropped
   task automatic host_read(input logic [2:0] code, output logic got);
      int i;
      @(negedge clk);
      hcode = code;
      hreq = 1'b1;
      got = 1'b0;
      for (i = 0; i < 3 && !got; i++) begin
         @(negedge clk);
         got = (ack === 1'b1);
      end
      if (got)
         @(negedge clk);
      hreq = 1'b0;
      @(negedge clk);
   endtask
   // start, nb bytes, good end; late raises the pin once the bytes are in
   task automatic send_frame(input rxfq_fclass_t f, input logic c, input int nb,
                             input logic late);
      @(negedge clk);
      st = 1'b1;
      fc = f;
      cp = c;
      @(negedge clk);
      st = 1'b0;
      repeat (nb) begin
         bv = 1'b1;
         bt = bt + 8'h01;
         @(negedge clk);
      end
      bv = 1'b0;
      if (late) begin
         pin = 1'b1;
         repeat (8) @(negedge clk);
      end
      en = 1'b1;
      gd = 1'b1;
      @(negedge clk);
      en = 1'b0;
      repeat (10) @(negedge clk);
   endtask
   // two-byte frame, then the count of words that reached each queue
   task automatic frame_to(input rxfq_fclass_t f, input logic c, input int e1, input int e2);
      int b1, b2;
      b1 = q1;
      b2 = q2;
      send_frame(f, c, 2, 1'b0);
      check(16'(q1 - b1), 16'(e1));
      check(16'(q2 - b2), 16'(e2));
      if (e1 + e2 > 0)
         check(16'(mlast), 16'(bt));
   endtask
   task automatic t_regs();
      reg_rd(OFS_MODE3, rv);
      check(rv, 16'h0000);
      reg_rd(OFS_PINCFG, rv);
      check(rv, 16'h0000);
      reg_rd(8'hff, rv);
      check(rv, 16'h0000);
      reg_wr(OFS_MODE1, 16'hffff);
      reg_rd(OFS_MODE1, rv);
      check(rv, 16'h7fff);
      check(16'(addet), 16'h0007);
      reg_wr(OFS_CMD2, 16'(CMD_SFR_RSVD));
      reg_rd(OFS_MODE1, rv);
      check(rv, 16'h7fff);
      reg_wr(OFS_MODE1, 16'h0000);
   endtask
   task automatic t_single();
      logic got;
      slow = 1'b1;
      frame_to(FC_SMT, 1'b1, 2, 0);
      frame_to(FC_MAC, 1'b1, 2, 0);
      slow = 1'b0;
      check(16'({dp1, dp2}), 16'h0002);
      host_read(HOST_SERVICE_REQUEST_CODE_Q2, got);
      check(16'(got), 16'h0000);
      host_read(HOST_SERVICE_REQUEST_CODE_Q1, got);
      check(16'(got), 16'h0001);
      reg_rd(OFS_STATUS_TWO_UPPER, rv);
      check(rv & 16'h8600, 16'h8000);
   endtask
   task automatic t_dual();
      logic got;
      reg_wr(OFS_MODE3, 16'h0800);
      reg_wr(OFS_FRSEL, 16'h0000);
      frame_to(FC_ASYNC_LLC, 1'b1, 2, 0);
      reg_wr(OFS_FRSEL, 16'h0002);
      frame_to(FC_SMT, 1'b1, 2, 0);
      frame_to(FC_ASYNC_LLC, 1'b1, 0, 2);
      frame_to(FC_IMPL, 1'b0, 0, 0);
      check(16'(dp2), 16'h0001);
      host_read(HOST_SERVICE_REQUEST_CODE_Q2, got);
      check(16'(got), 16'h0001);
      check(16'(haddr), 16'h0100);
      reg_rd(OFS_STATUS_THREE_UPPER, rv);
      check(rv & 16'h8000, 16'h8000);
      reg_wr(OFS_FRSEL, 16'h0061);
      frame_to(FC_SYNC_LLC, 1'b1, 2, 0);
      reg_wr(OFS_FRSEL, 16'h0050);
      frame_to(FC_SMT, 1'b1, 0, 0);
      frame_to(FC_MAC, 1'b1, 0, 2);
      reg_wr(OFS_FRSEL, 16'h0022);
      frame_to(FC_ASYNC_LLC, 1'b1, 2, 0);
      reg_wr(OFS_FRSEL, 16'h0023);
      frame_to(FC_VOID, 1'b1, 0, 0);
      frame_to(FC_IMPL, 1'b1, 2, 0);
      reg_wr(OFS_MODE1, 16'h0007);
      frame_to(FC_VOID, 1'b1, 2, 0);
      frame_to(FC_SMT, 1'b1, 0, 2);
      reg_wr(OFS_MODE1, 16'h0000);
      reg_wr(OFS_MODE3, 16'h0000);
   endtask
   // pin changes need several cycles to pass the synchroniser
   task automatic set_pin(input logic [1:0] cfg, input logic lvl);
      reg_wr(OFS_PINCFG, 16'(cfg));
      pin = lvl;
      repeat (8) @(negedge clk);
   endtask
   task automatic t_pin();
      set_pin(PIN_FN_FLUSH, 1'b1);
      check(16'(inh), 16'h0000);
      frame_to(FC_SMT, 1'b1, 0, 0);
      reg_rd(OFS_STATUS_TWO_UPPER, rv);
      check(rv & 16'h2000, 16'h2000);
      set_pin(PIN_FN_FLUSH, 1'b0);
      frame_to(FC_SMT, 1'b1, 2, 0);
      set_pin(PIN_FN_INHIBIT, 1'b1);
      check(16'(inh), 16'h0001);
      frame_to(FC_SMT, 1'b1, 2, 0);
      set_pin(PIN_FN_INHIBIT, 1'b0);
      check(16'(inh), 16'h0000);
      set_pin(2'h3, 1'b1);
      check(16'(inh), 16'h0000);
      frame_to(FC_SMT, 1'b1, 2, 0);
      set_pin(PIN_FN_NORMAL, 1'b0);
   endtask
   // a pin raised after the threshold is crossed must not flush
   task automatic t_thresh();
      int b1;
      reg_wr(OFS_RXTHR, 16'h0002);
      set_pin(PIN_FN_FLUSH, 1'b0);
      reg_rd(OFS_STATUS_TWO_UPPER, rv);
      b1 = q1;
      send_frame(FC_SMT, 1'b1, 2, 1'b1);
      check(16'(q1 - b1), 16'h0002);
      reg_rd(OFS_STATUS_TWO_UPPER, rv);
      check(rv & 16'ha000, 16'h8000);
      set_pin(PIN_FN_FLUSH, 1'b1);
      frame_to(FC_SMT, 1'b1, 0, 0);
      set_pin(PIN_FN_NORMAL, 1'b0);
      reg_wr(OFS_RXTHR, 16'h0000);
   endtask
   // 255 bytes never fit beside what queue one already holds, so it locks
   task automatic t_lock();
      send_frame(FC_SMT, 1'b1, 255, 1'b0);
      reg_rd(OFS_STATUS_TWO_UPPER, rv);
      check(rv & 16'h1800, 16'h1800);
      frame_to(FC_SMT, 1'b1, 0, 0);
      reg_wr(OFS_CMD1, 16'(CMD_CLR_LOCK2));
      frame_to(FC_SMT, 1'b1, 0, 0);
      reg_wr(OFS_CMD1, 16'(CMD_CLR_LOCK1));
      frame_to(FC_SMT, 1'b1, 2, 0);
      send_frame(FC_SMT, 1'b1, 255, 1'b0);
      reg_wr(OFS_CMD1, 16'(CMD_CLR_ALL));
      frame_to(FC_SMT, 1'b1, 2, 0);
   endtask
   initial begin
      failures = 0;
      n_compared = 0;
      {rst_n, pin, wr, rd, st, cp, bv, en, gd, hreq, slow} = '0;
      addr = 8'h00;
      bt = 8'h00;
      wd = 16'h0000;
      hcode = 3'h0;
      fc = FC_OTHER;
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_regs();
      t_single();
      t_dual();
      t_pin();
      t_thresh();
      t_lock();
      stop_test();
   end
   initial begin
      #60000;
      failures++;
      stop_test();
   end
endmodule // test_rx_flush_dual_queue_steering
